// ===== design/rx_pkg.sv
package rx_pkg;

  // sub-bit phase numbering of the oversampled bit time
  localparam logic [4:0] RT_FIRST      = 5'h01;
  localparam logic [4:0] RT_SECOND     = 5'h02;
  localparam logic [4:0] RT_LAST       = 5'h10;
  localparam logic [4:0] RT_VOTE_A     = 5'h03;
  localparam logic [4:0] RT_VOTE_B     = 5'h05;
  localparam logic [4:0] RT_VOTE_C     = 5'h07;
  localparam logic [4:0] RT_MAJ_A      = 5'h08;
  localparam logic [4:0] RT_MAJ_B      = 5'h09;
  localparam logic [4:0] RT_MAJ_C      = 5'h0A;
  localparam logic [4:0] RT_RESYNC_MIN = 5'h0B;

  // frame geometry
  localparam logic [3:0] DATA_BITS_8   = 4'h8;
  localparam logic [3:0] DATA_BITS_9   = 4'h9;
  localparam logic [7:0] IDLE_TICKS_8  = 8'hA0;  // 10 bit times of 16 phases
  localparam logic [7:0] IDLE_TICKS_9  = 8'hB0;  // 11 bit times of 16 phases
  localparam logic [2:0] HIST_ALL_HIGH = 3'h7;
  localparam logic [2:0] HIST_CLEAR    = 3'h0;
  localparam logic [1:0] VOTE_MIN_LOW  = 2'h2;

  // defaults
  localparam int         FIFO_DEPTH    = 32;
  localparam logic [12:0] BAUD_DIV_MIN = 13'h0001;

  typedef enum logic [1:0] {
    ST_HUNT,
    ST_START,
    ST_DATA,
    ST_STOP
  } frame_state_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_char_t;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic idle_irq_en;
    logic overrun_irq_en;
    logic noise_irq_en;
    logic frame_irq_en;
    logic parity_irq_en;
  } irq_enable_t;

  typedef struct packed {
    logic rx_buffer_full;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic frame_error_flag;
    logic parity_error_flag;
  } rx_status_t;

endpackage

// ===== design/async_serial_receiver_wakeup.sv
`timescale 1ns/100ps
`default_nettype none

// character stream buffer with a registered output stage
module rx_stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push = in_valid_i && in_ready_o;
  assign pop  = (count != '0) && (!out_valid_o || out_ready_i);

  // storage and pointers; ready is registered so it drops one word early
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count      <= count + (AW+1)'(push) - (AW+1)'(pop);
      in_ready_o <= (count + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH - 1);
    end
  end

  // output stage keeps the stream port driven straight from flops
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

module async_serial_receiver_wakeup
  import rx_pkg::*;
#(
  parameter int DEPTH = rx_pkg::FIFO_DEPTH
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               serial_rx_pin_i,
  input  wire logic [12:0]        baud_div_i,
  input  wire logic               receiver_on_i,
  input  wire logic               nine_bit_mode_i,
  input  wire logic               parity_on_i,
  input  wire logic               parity_odd_i,
  input  wire logic               wake_select_i,
  input  wire logic               quiet_count_start_select_i,
  input  wire logic               sleep_request_i,
  input  wire logic               status_read_i,
  input  wire logic               data_read_i,
  input  wire rx_pkg::irq_enable_t irq_enable_i,
  input  wire logic               tx_buffer_empty_i,
  input  wire logic               transmit_done_i,
  input  wire logic               tx_ninth_bit_i,
  input  wire logic               tx_load_i,
  input  wire logic               stream_ready_i,
  output logic                    stream_valid_o,
  output rx_pkg::rx_char_t        stream_data_o,
  output rx_pkg::rx_char_t        data_port_o,
  output rx_pkg::rx_status_t      status_one_o,
  output logic                    rx_sleep_o,
  output logic                    tx_ninth_latched_o,
  output logic                    tx_irq_o,
  output logic                    rx_irq_o,
  output logic                    err_irq_o
);
  import rx_pkg::*;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic split3(input logic a, input logic b, input logic c);
    split3 = !((a == b) && (b == c));
  endfunction

  logic         rx_meta;
  logic         rx_s;
  logic [12:0]  div_cnt;
  logic         tick;
  logic [2:0]   hist;
  logic         edge_seen;
  frame_state_t state;
  logic [4:0]   rt;
  logic [1:0]   start_lows;
  logic         v8;
  logic         v9;
  logic         noisy;
  logic         par_acc;
  logic [3:0]   bitn;
  logic [8:0]   shreg;
  logic [7:0]   idle_cnt;
  logic         idle_armed;
  logic         arm_full;
  logic         arm_idle;
  logic         arm_err;
  logic         fifo_ready;

  logic         bit_level;
  logic         bit_noise;
  logic         bit_end;
  logic         last_bit;
  logic         stop_now;
  logic         stop_level;
  logic         is_break;
  logic         frame_noise;
  logic         char_done;
  logic         awake_ok;
  logic         do_load;
  logic         do_overrun;
  logic         addr_wake;
  logic         idle_hit;
  logic         idle_wake;
  logic         idle_set;
  logic         clear_now;
  logic         count_ok;
  logic [7:0]   idle_target;
  logic [3:0]   nbits;
  rx_char_t     char_in;

  // two flops before anything reads the pin
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
    end else begin
      rx_meta <= serial_rx_pin_i;
      rx_s    <= rx_meta;
    end
  end

  // 16x sample tick; a zero divisor behaves as one to avoid a dead receiver
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 13'h0001;
    end
  end
  assign tick = (div_cnt + BAUD_DIV_MIN >= baud_div_i);

  assign nbits       = nine_bit_mode_i ? DATA_BITS_9 : DATA_BITS_8;
  assign idle_target = nine_bit_mode_i ? IDLE_TICKS_9 : IDLE_TICKS_8;

  // edge search looks at every tick in every state
  assign edge_seen = tick && (hist == HIST_ALL_HIGH) && !rx_s;

  // per-bit decision at phase 10
  assign bit_level = maj3(v8, v9, rx_s);
  assign bit_noise = split3(v8, v9, rx_s);
  assign last_bit  = (bitn == nbits - 4'h1);
  assign bit_end   = tick && (state == ST_DATA) &&
                     ((rt == RT_LAST) || (edge_seen && rt >= RT_RESYNC_MIN));
  assign stop_now  = tick && (state == ST_STOP) && (rt == RT_MAJ_C);
  assign stop_level = bit_level;
  assign char_in   = nine_bit_mode_i ? rx_char_t'(shreg) : rx_char_t'({1'b0, shreg[8:1]});
  assign is_break  = (char_in == '0) && !stop_level;
  assign frame_noise = noisy || bit_noise;
  assign char_done = stop_now;

  // flags only set while awake and enabled; data-read clears work in any state
  assign awake_ok   = receiver_on_i && !rx_sleep_o;
  assign do_load    = char_done && awake_ok && !status_one_o.frame_error_flag &&
                      !status_one_o.rx_buffer_full && fifo_ready;
  assign do_overrun = char_done && awake_ok && !status_one_o.frame_error_flag &&
                      (status_one_o.rx_buffer_full || !fifo_ready);
  assign addr_wake  = tick && (state == ST_DATA) && (rt == RT_MAJ_C) && last_bit &&
                      bit_level && wake_select_i && rx_sleep_o;

  // hold the line history; framing error on a non-break refills it with highs
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !receiver_on_i) begin
      hist <= HIST_CLEAR;
    end else if (stop_now && !stop_level && !is_break) begin
      hist <= HIST_ALL_HIGH;
    end else if (tick) begin
      hist <= {hist[1:0], rx_s};
    end
  end

  // frame sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !receiver_on_i) begin
      state      <= ST_HUNT;
      rt         <= RT_FIRST;
      start_lows <= '0;
      v8         <= 1'b1;
      v9         <= 1'b1;
      noisy      <= 1'b0;
      par_acc    <= 1'b0;
      bitn       <= '0;
      shreg      <= '0;
    end else if (tick) begin
      rt <= rt + 5'h01;
      if (rt == RT_MAJ_A) begin
        v8 <= rx_s;
      end
      if (rt == RT_MAJ_B) begin
        v9 <= rx_s;
      end
      case (state)
        ST_HUNT: begin
          if (edge_seen) begin
            state      <= ST_START;
            rt         <= RT_SECOND;
            start_lows <= '0;
            noisy      <= 1'b0;
            par_acc    <= 1'b0;
            bitn       <= '0;
          end
        end
        ST_START: begin
          if (rt == RT_VOTE_A || rt == RT_VOTE_B) begin
            start_lows <= start_lows + 2'(!rx_s);
            if (rx_s) begin
              noisy <= 1'b1;
            end
          end
          if (rt == RT_VOTE_C) begin
            if (start_lows + 2'(!rx_s) < VOTE_MIN_LOW) begin
              state <= ST_HUNT;
            end
            if (rx_s) begin
              noisy <= 1'b1;
            end
          end
          if (rt >= RT_MAJ_A && rt <= RT_MAJ_C && rx_s) begin
            noisy <= 1'b1;
          end
          if (rt == RT_LAST) begin
            state <= ST_DATA;
            rt    <= RT_FIRST;
          end
        end
        ST_DATA: begin
          if (rt == RT_MAJ_C) begin
            shreg   <= {bit_level, shreg[8:1]};
            par_acc <= par_acc ^ bit_level;
            if (bit_noise) begin
              noisy <= 1'b1;
            end
          end
          if (bit_end) begin
            rt   <= edge_seen ? RT_SECOND : RT_FIRST;
            bitn <= bitn + 4'h1;
            if (last_bit) begin
              state <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (rt == RT_MAJ_C) begin
            state <= ST_HUNT;
          end
        end
        default: begin
          state <= ST_HUNT;
        end
      endcase
    end
  end

  // idle counter in phase ticks of high line
  assign count_ok = quiet_count_start_select_i ? (state == ST_HUNT)
                                               : (state != ST_START);
  assign idle_hit  = tick && count_ok && rx_s && (idle_cnt == idle_target - 8'h01);
  assign idle_wake = idle_hit && receiver_on_i && rx_sleep_o && !wake_select_i;
  assign idle_set  = idle_hit && awake_ok && idle_armed;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !receiver_on_i) begin
      idle_cnt <= '0;
    end else if (tick) begin
      if (!count_ok || !rx_s) begin
        idle_cnt <= '0;
      end else if (idle_cnt != idle_target) begin
        idle_cnt <= idle_cnt + 8'h01;  // saturates so one idle period fires once
      end
    end
  end

  // idle may fire only once per received character
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      idle_armed <= 1'b1;
    end else if (do_load) begin
      idle_armed <= 1'b1;
    end else if (idle_set) begin
      idle_armed <= 1'b0;
    end
  end

  // sleep: software set wins over a wakeup in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_sleep_o <= 1'b0;
    end else if (sleep_request_i) begin
      rx_sleep_o <= 1'b1;
    end else if (idle_wake || addr_wake) begin
      rx_sleep_o <= 1'b0;
    end
  end

  // two-step clear: status read arms each set flag, data read clears it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || data_read_i) begin
      arm_full <= 1'b0;
      arm_idle <= 1'b0;
      arm_err  <= 1'b0;
    end else if (status_read_i) begin
      arm_full <= status_one_o.rx_buffer_full;
      arm_idle <= status_one_o.idle_flag;
      arm_err  <= status_one_o.overrun_flag | status_one_o.noise_flag |
                  status_one_o.frame_error_flag | status_one_o.parity_error_flag;
    end
  end
  assign clear_now = data_read_i;

  // full flag and buffer; a new set beats a same-cycle clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_one_o.rx_buffer_full <= 1'b0;
      data_port_o                 <= '0;
    end else if (do_load) begin
      status_one_o.rx_buffer_full <= 1'b1;
      data_port_o                 <= char_in;
    end else if (clear_now && arm_full) begin
      status_one_o.rx_buffer_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_one_o.idle_flag <= 1'b0;
    end else if (idle_set) begin
      status_one_o.idle_flag <= 1'b1;
    end else if (clear_now && arm_idle) begin
      status_one_o.idle_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_one_o.overrun_flag <= 1'b0;
    end else if (do_overrun) begin
      status_one_o.overrun_flag <= 1'b1;
    end else if (clear_now && arm_err) begin
      status_one_o.overrun_flag <= 1'b0;
    end
  end

  // error flags ride with the load; an overrun leaves them untouched
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_one_o.noise_flag        <= 1'b0;
      status_one_o.frame_error_flag  <= 1'b0;
      status_one_o.parity_error_flag <= 1'b0;
    end else if (do_load) begin
      status_one_o.noise_flag        <= frame_noise;
      status_one_o.frame_error_flag  <= !stop_level;
      status_one_o.parity_error_flag <= parity_on_i && (par_acc != parity_odd_i);
    end else if (clear_now && arm_err) begin
      status_one_o.noise_flag        <= 1'b0;
      status_one_o.frame_error_flag  <= 1'b0;
      status_one_o.parity_error_flag <= 1'b0;
    end
  end

  // transmit ninth bit follows the data byte into the shifter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_ninth_latched_o <= 1'b0;
    end else if (tx_load_i) begin
      tx_ninth_latched_o <= tx_ninth_bit_i;
    end
  end

  // three request lines, each source gated by its own enable
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_irq_o  <= 1'b0;
      rx_irq_o  <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      tx_irq_o  <= (tx_buffer_empty_i && irq_enable_i.tx_empty_irq_en) ||
                   (transmit_done_i && irq_enable_i.tx_done_irq_en);
      rx_irq_o  <= (status_one_o.rx_buffer_full && irq_enable_i.rx_full_irq_en) ||
                   (status_one_o.idle_flag && irq_enable_i.idle_irq_en);
      err_irq_o <= (status_one_o.overrun_flag && irq_enable_i.overrun_irq_en) ||
                   (status_one_o.noise_flag && irq_enable_i.noise_irq_en) ||
                   (status_one_o.frame_error_flag && irq_enable_i.frame_irq_en) ||
                   (status_one_o.parity_error_flag && irq_enable_i.parity_irq_en);
    end
  end

  // every buffered character is also queued on the stream; a full queue counts as overrun
  rx_stream_fifo #(
    .WIDTH ($bits(rx_char_t)),
    .DEPTH (DEPTH)
  ) u_stream (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (do_load),
    .in_ready_o  (fifo_ready),
    .in_data_i   (char_in),
    .out_valid_o (stream_valid_o),
    .out_ready_i (stream_ready_i),
    .out_data_o  (stream_data_o)
  );

endmodule
`default_nettype wire

// ===== tb/rx_line_driver.sv
`timescale 1ns/100ps
`default_nettype none

// far-end transmitter: one bit per 16 clocks, since the bench runs baud_div at 1
module rx_line_driver (
  input  wire logic ref_clk_i,
  output logic      line_o
);
  initial line_o = 1'b1;

  // glitch flips one clock of one bit, so that bit's majority still holds
  task automatic send(input logic [8:0] ch, input logic nine, input logic stop,
                      input int glitch);
    logic [10:0] fr;
    fr = nine ? {stop, ch, 1'b0} : {1'b0, stop, ch[7:0], 1'b0};
    for (int b = 0; b < (nine ? 11 : 10); b++) begin
      for (int k = 0; k < 16; k++) begin
        @(posedge ref_clk_i);
        #1 line_o = fr[b] ^ (b == glitch && k == 8);
      end
    end
    @(posedge ref_clk_i);
    #1 line_o = 1'b1; // mark level between frames
  endtask
endmodule

`default_nettype wire

// ===== tb/async_serial_receiver_wakeup_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module rx_wake_checker
  import rx_pkg::*;
(
  input wire logic                ref_clk_i,
  input wire logic                rst_i,
  input wire logic                receiver_on_i,
  input wire logic                data_read_i,
  input wire rx_pkg::irq_enable_t irq_enable_i,
  input wire logic                tx_buffer_empty_i,
  input wire logic                transmit_done_i,
  input wire logic                tx_ninth_bit_i,
  input wire logic                tx_load_i,
  input wire rx_pkg::rx_status_t  status_one_o,
  input wire logic                rx_sleep_o,
  input wire logic                tx_ninth_latched_o,
  input wire logic                tx_irq_o,
  input wire logic                rx_irq_o,
  input wire logic                err_irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  rx_status_t st;
  assign st = status_one_o;

  // flag causes and clears
  sleep_blocks_full_a: assert property ($rose(st.rx_buffer_full) |-> !$past(rx_sleep_o))
    else $error("full flag rose while asleep");
  off_blocks_full_a: assert property ($rose(st.rx_buffer_full) |-> $past(receiver_on_i))
    else $error("full flag rose while receiver off");
  full_clear_a: assert property ($fell(st.rx_buffer_full) |-> $past(data_read_i))
    else $error("full flag cleared without data read");
  overrun_quiet_a: assert property ($rose(st.overrun_flag) |->
    $stable({st.noise_flag, st.frame_error_flag, st.parity_error_flag}))
    else $error("error flags changed on overrun");
  err_with_full_a: assert property ($rose(st.noise_flag) || $rose(st.parity_error_flag) ||
    $rose(st.frame_error_flag) |-> $rose(st.rx_buffer_full))
    else $error("error flag set apart from full flag");

  // requests follow enabled sources one cycle later; the ninth bit copies on load
  rx_irq_a: assert property (rx_irq_o == $past(st.rx_buffer_full && irq_enable_i.rx_full_irq_en
    || st.idle_flag && irq_enable_i.idle_irq_en))
    else $error("receive request wrong");
  err_irq_a: assert property (err_irq_o == $past(st.overrun_flag && irq_enable_i.overrun_irq_en
    || st.noise_flag && irq_enable_i.noise_irq_en || st.frame_error_flag
    && irq_enable_i.frame_irq_en || st.parity_error_flag && irq_enable_i.parity_irq_en))
    else $error("error request wrong");
  tx_irq_a: assert property (tx_irq_o == $past(tx_buffer_empty_i && irq_enable_i.tx_empty_irq_en
    || transmit_done_i && irq_enable_i.tx_done_irq_en))
    else $error("transmit request wrong");
  ninth_copy_a: assert property (tx_load_i |=> tx_ninth_latched_o == $past(tx_ninth_bit_i))
    else $error("ninth bit not copied on load");

  full_c: cover property ($rose(st.rx_buffer_full));
  overrun_c: cover property ($rose(st.overrun_flag));
  wake_c: cover property ($fell(rx_sleep_o));
endmodule

bind async_serial_receiver_wakeup rx_wake_checker u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .receiver_on_i(receiver_on_i),
  .data_read_i(data_read_i), .irq_enable_i(irq_enable_i),
  .tx_buffer_empty_i(tx_buffer_empty_i), .transmit_done_i(transmit_done_i),
  .tx_ninth_bit_i(tx_ninth_bit_i), .tx_load_i(tx_load_i), .status_one_o(status_one_o),
  .rx_sleep_o(rx_sleep_o), .tx_ninth_latched_o(tx_ninth_latched_o),
  .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o)
);

`default_nettype wire

// ===== tb/async_serial_receiver_wakeup_tb.sv
`timescale 1ns/100ps
`default_nettype none

module async_serial_receiver_wakeup_tb;
  import rx_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        line;
  logic        on = 1'b1, nine = 1'b0, par_on = 1'b0, par_odd = 1'b0, wake = 1'b0;
  logic        quiet = 1'b0, sleep_rq = 1'b0, st_rd = 1'b0, d_rd = 1'b0, tx_emp = 1'b0;
  logic        tx_done = 1'b0, tx9 = 1'b0, tx_ld = 1'b0, s_rdy = 1'b1;
  irq_enable_t ien = 8'h00;
  logic        s_vld, sleep, tx9_l, tx_irq, rx_irq, err_irq;
  rx_char_t    s_dat, dport;
  rx_status_t  stat;
  int          bad_count = 0, checks_done = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  rx_line_driver u_drv (.ref_clk_i(ref_clk_i), .line_o(line));

  // small depth so the stall test reaches the refusal quickly
  async_serial_receiver_wakeup #(.DEPTH(4)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_rx_pin_i(line),
    .baud_div_i(13'h0001), .receiver_on_i(on), .nine_bit_mode_i(nine),
    .parity_on_i(par_on), .parity_odd_i(par_odd), .wake_select_i(wake),
    .quiet_count_start_select_i(quiet), .sleep_request_i(sleep_rq),
    .status_read_i(st_rd), .data_read_i(d_rd), .irq_enable_i(ien),
    .tx_buffer_empty_i(tx_emp), .transmit_done_i(tx_done), .tx_ninth_bit_i(tx9),
    .tx_load_i(tx_ld), .stream_ready_i(s_rdy), .stream_valid_o(s_vld),
    .stream_data_o(s_dat), .data_port_o(dport), .status_one_o(stat),
    .rx_sleep_o(sleep), .tx_ninth_latched_o(tx9_l), .tx_irq_o(tx_irq),
    .rx_irq_o(rx_irq), .err_irq_o(err_irq));

  // every drive lands 1 ns after the edge
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    wt(1);
    s = 1'b0;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic clr;
    pulse(st_rd);
    pulse(d_rd);
    wt(1);
  endtask

  // let a pending idle flag appear, then clear it so every test starts clean
  task automatic fresh;
    wt(200);
    clr;
  endtask

  task automatic rx(input logic [8:0] c, input logic s, input int g);
    u_drv.send(c, nine, s, g);
    wt(4);
  endtask

  task automatic t_basic;
    fresh;
    rx(9'h0a5, 1'b1, -1);
    chk(dport, 9'h0a5);
    chk({3'h0, stat}, 9'h020);
    pulse(d_rd);
    wt(1);
    chk({3'h0, stat}, 9'h020);
    clr;
    chk({3'h0, stat}, 9'h000);
    $display("basic done");
  endtask

  task automatic t_err;
    fresh;
    rx(9'h055, 1'b1, 2);
    chk({3'h0, stat}, 9'h024);
    clr;
    par_on = 1'b1;
    rx(9'h001, 1'b1, -1);
    chk({3'h0, stat}, 9'h021);
    clr;
    par_odd = 1'b1;
    rx(9'h001, 1'b1, -1);
    chk({3'h0, stat}, 9'h020);
    clr;
    par_on = 1'b0;
    rx(9'h0f0, 1'b0, -1);
    chk({3'h0, stat}, 9'h022);
    // the refilled edge history treats the rest of the low stop bit as a new start
    clr;
    fresh;
    rx(9'h000, 1'b0, -1);
    chk({3'h0, stat}, 9'h022);
    clr;
    $display("errors done");
  endtask

  task automatic t_over;
    fresh;
    ien = 8'hff;
    rx(9'h03c, 1'b1, -1);
    rx(9'h081, 1'b1, 1);
    chk(dport, 9'h03c);
    chk({3'h0, stat}, 9'h028);
    chk({6'h00, rx_irq, err_irq, tx_irq}, 9'h006);
    ien = 8'h20;
    wt(3);
    chk({6'h00, rx_irq, err_irq, tx_irq}, 9'h004);
    ien = 8'h08;
    wt(3);
    chk({6'h00, rx_irq, err_irq, tx_irq}, 9'h002);
    tx_emp = 1'b1;
    ien = 8'h80;
    wt(3);
    chk({6'h00, rx_irq, err_irq, tx_irq}, 9'h001);
    tx_emp = 1'b0;
    tx_done = 1'b1;
    ien = 8'h40;
    wt(3);
    chk({6'h00, rx_irq, err_irq, tx_irq}, 9'h001);
    tx_done = 1'b0;
    ien = 8'h00;
    clr;
    $display("overrun done");
  endtask

  task automatic t_nine;
    fresh;
    nine = 1'b1;
    rx(9'h10f, 1'b1, -1);
    chk(dport, 9'h10f);
    clr;
    nine = 1'b0;
    tx9 = 1'b1;
    pulse(tx_ld);
    wt(1);
    chk({8'h00, tx9_l}, 9'h001);
    tx9 = 1'b0;
    pulse(tx_ld);
    wt(1);
    chk({8'h00, tx9_l}, 9'h000);
    on = 1'b0;
    rx(9'h0aa, 1'b1, -1);
    chk({3'h0, stat}, 9'h000);
    on = 1'b1;
    $display("ninth and off done");
  endtask

  // the second pass waits past the point where a count from the start bit would wake
  task automatic t_idle;
    for (int q = 0; q < 2; q++) begin
      fresh;
      quiet = q[0];
      pulse(sleep_rq);
      rx(9'h011, 1'b1, -1);
      chk({3'h0, stat}, 9'h000);
      wt(q == 0 ? 116 : 151);
      chk({8'h00, sleep}, 9'h001);
      wt(60);
      chk({8'h00, sleep}, 9'h000);
      chk({3'h0, stat}, 9'h000);
      rx(9'h022, 1'b1, -1);
      chk({3'h0, stat}, 9'h020);
      wt(200);
      chk({3'h0, stat}, 9'h030);
      clr;
      wt(200);
      chk({3'h0, stat}, 9'h000);
    end
    quiet = 1'b0;
    $display("idle wake done");
  endtask

  task automatic t_addr;
    fresh;
    wake = 1'b1;
    pulse(sleep_rq);
    rx(9'h012, 1'b1, -1);
    chk({8'h00, sleep}, 9'h001);
    rx(9'h092, 1'b1, -1);
    chk({8'h00, sleep}, 9'h000);
    chk(dport, 9'h092);
    chk({3'h0, stat}, 9'h020);
    clr;
    wake = 1'b0;
    $display("address wake done");
  endtask

  task automatic t_fifo;
    int n;
    n = 0;
    fresh;
    s_rdy = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rx({1'b0, 8'h40 + 8'(i)}, 1'b1, -1);
      if (i < 6) clr;
    end
    chk({3'h0, stat}, 9'h008);
    s_rdy = 1'b1;
    repeat (12) begin
      if (s_vld === 1'b1) begin
        chk(s_dat, {1'b0, 8'h40 + 8'(n)});
        n++;
      end
      wt(1);
    end
    chk({8'h00, n >= 4 && n <= 5}, 9'h001);
    clr;
    $display("stream fifo done");
  endtask

  task automatic test_done;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk_i);
    bad_count++;
    test_done;
  end

  initial begin
    repeat (20) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    wt(2);
    t_basic;
    t_err;
    t_over;
    t_nine;
    t_idle;
    t_addr;
    t_fifo;
    test_done;
  end
endmodule

`default_nettype wire
